// file: verilog/wake_event_runtime_block.v
// Wake event logic with its runtime register block on the host I/O port
`timescale 1ns/1ps
`default_nettype none
`include "wake_event_defs.vh"

// Summary of operation
// - Ring indicators and wake GPIO edges raise wake events.
// - Polarity config bit 5 selects wake output active high or low.
// - With config at reset, wake output is active low, open drain.
// - Driver type config bit 7 selects open drain or push-pull.
// - Global enable clear blocks the wake output entirely.
// - Global enable set lets any enabled source assert the wake output.
// - Source status bits record events regardless of any enable.
// - Global status bit 0 sets when any source status and enable both set.
// - Sources must be cleared before global clears; source clears on written one.
// - GPIO polarity picks the edge; non-inverted means rising edge.
// - Writing one clears global status, stopping the output; zero does nothing.
// - Global enable bit 0 resets to zero, disabling the output.
// - Decode compares address bits 11:4 to base, needs bits 15:12 zero.
// - No decode while the programmed base is below 0x100.
// - Wake registers reset to zero only on standby power-on reset.
// - Reserved bits read zero.
// - Parallel interrupt status reads one while port unpowered, else follows acknowledge.
module wake_event_runtime_block (
    // Clock and standby power-on reset
    input wire clk_sys,
    input wire sys_rst,
    // Host I/O register port
    input wire [15:0] io_addr,
    input wire io_wr,
    input wire io_rd,
    input wire [7:0] io_wdata,
    output reg [7:0] io_rdata,
    output reg io_rdata_valid,
    // Configuration inputs from the configuration register file
    input wire [15:0] runtime_base_config,
    input wire [7:0] gpio_polarity_config_2,
    input wire [7:0] gpio_driver_type_config,
    input wire [20:0] gpio_wake_polarity,
    input wire parallel_port_power,
    // Wake source pins and the printer acknowledge pin
    input wire ring_indicate_in_a_n,
    input wire ring_indicate_in_b_n,
    input wire [20:0] gpio_wake_in,
    input wire printer_ack_in_n,
    // Wake output pin, open-drain capable
    output reg wake_event_out,
    output reg wake_event_oe
);

    // ==========================================================
    // Source vector assembly
    wire [23:0] src_raw;
    wire [23:0] src_pol;
    // Ring indicators are active low: the falling edge is the active transition
    assign src_raw = {gpio_wake_in[20:13], 1'b0, gpio_wake_in[12:8],
                      ~ring_indicate_in_b_n, ~ring_indicate_in_a_n, gpio_wake_in[7:0]};
    assign src_pol = {gpio_wake_polarity[20:13], 1'b0, gpio_wake_polarity[12:8],
                      2'b00, gpio_wake_polarity[7:0]};

    // ==========================================================
    // Synchronisers and edge detectors
    reg [23:0] sync1_q;
    reg [23:0] sync2_q;
    reg [23:0] prev_q;
    wire [23:0] src_evt;

    genvar g;
    generate
        for (g = 0; g < `SRC_COUNT; g = g + 1) begin : g_src
            always @(posedge clk_sys) begin
                if (sys_rst) begin
                    sync1_q[g] <= 1'b0;
                    sync2_q[g] <= 1'b0;
                    // Prime to the idle level so an inverted pin gives no false edge at release
                    prev_q[g] <= src_pol[g];
                end else begin
                    sync1_q[g] <= src_raw[g];
                    sync2_q[g] <= sync1_q[g];
                    prev_q[g] <= sync2_q[g] ^ src_pol[g];
                end
            end
            assign src_evt[g] = (sync2_q[g] ^ src_pol[g]) & ~prev_q[g];
        end
    endgenerate

    // ==========================================================
    // Printer acknowledge synchroniser
    reg ack1_q;
    reg ack2_q;
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            ack1_q <= 1'b1;
            ack2_q <= 1'b1;
        end else begin
            ack1_q <= printer_ack_in_n;
            ack2_q <= ack1_q;
        end
    end

    // ==========================================================
    // Address decode
    wire base_ok;
    wire hit;
    wire [3:0] ofs;
    assign base_ok = (runtime_base_config[11:0] >= `BASE_MINIMUM) &&
                     (runtime_base_config[15:12] == `ADDR_UPPER_ZERO);
    // 16-bit qualification, low nibble is the offset
    assign hit = base_ok && (io_addr[15:12] == `ADDR_UPPER_ZERO) &&
                 (io_addr[11:4] == runtime_base_config[11:4]);
    assign ofs = io_addr[3:0];
    wire wr_hit;
    assign wr_hit = hit & io_wr;

    // ==========================================================
    // Register state
    reg global_sts_q;
    reg global_en_q;
    reg [23:0] src_sts_q;
    reg [23:0] src_en_q;
    reg [7:0] sysmgmt_status_1_q;
    reg [7:0] sysmgmt_status_2_q;
    reg [7:0] sysmgmt_enable_1_q;
    reg [7:0] sysmgmt_enable_2_q;
    reg [7:0] gp_data_q [0:3];

    // Write-one masks for the three source status bytes
    reg [23:0] src_clr;
    reg [23:0] src_en_d;
    always @* begin
        src_clr = `RST_SRC24;
        src_en_d = src_en_q;
        if (wr_hit) begin
            case (ofs)
                `OFS_WAKE_SOURCE_STATUS_1: src_clr[7:0] = io_wdata;
                `OFS_WAKE_SOURCE_STATUS_2: src_clr[15:8] = io_wdata;
                `OFS_WAKE_SOURCE_STATUS_3: src_clr[23:16] = io_wdata;
                `OFS_WAKE_SOURCE_ENABLE_1: src_en_d[7:0] = io_wdata;
                `OFS_WAKE_SOURCE_ENABLE_2: src_en_d[15:8] = io_wdata;
                `OFS_WAKE_SOURCE_ENABLE_3: src_en_d[23:16] = io_wdata;
                default: src_clr = `RST_SRC24;
            endcase
        end
    end

    wire any_pending;
    assign any_pending = |(src_sts_q & src_en_q);

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            src_sts_q <= `RST_SRC24;
            src_en_q <= `RST_SRC24;
            global_sts_q <= 1'b0;
            global_en_q <= 1'b0;
        end else begin
            src_sts_q <= ((src_sts_q & ~src_clr) | src_evt) & `SRC_IMPLEMENTED_MASK;
            src_en_q <= src_en_d & `SRC_IMPLEMENTED_MASK;
            if (any_pending) begin
                global_sts_q <= 1'b1;
            end else if (wr_hit && ofs == `OFS_WAKE_GLOBAL_STATUS &&
                         io_wdata[`BIT_GLOBAL_STATUS]) begin
                global_sts_q <= 1'b0;
            end
            if (wr_hit && ofs == `OFS_WAKE_GLOBAL_ENABLE) begin
                global_en_q <= io_wdata[`BIT_GLOBAL_ENABLE];
            end
        end
    end

    // ==========================================================
    // System management and GPIO data storage; their own logic lives elsewhere
    integer i;
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            sysmgmt_status_1_q <= `RST_REG8;
            sysmgmt_status_2_q <= `RST_SYSMGMT_STATUS_2;
            sysmgmt_enable_1_q <= `RST_REG8;
            sysmgmt_enable_2_q <= `RST_REG8;
            for (i = 0; i < 4; i = i + 1) begin
                gp_data_q[i] <= `RST_REG8;
            end
        end else if (wr_hit) begin
            case (ofs)
                `OFS_SYSMGMT_STATUS_1: sysmgmt_status_1_q <= io_wdata;
                `OFS_SYSMGMT_STATUS_2: sysmgmt_status_2_q <= io_wdata;
                `OFS_SYSMGMT_ENABLE_1: sysmgmt_enable_1_q <= io_wdata;
                `OFS_SYSMGMT_ENABLE_2: sysmgmt_enable_2_q <= io_wdata;
                `OFS_GPIO_DATA_PORT_1: gp_data_q[0] <= io_wdata;
                `OFS_GPIO_DATA_PORT_2: gp_data_q[1] <= io_wdata;
                `OFS_GPIO_DATA_PORT_3: gp_data_q[2] <= io_wdata;
                `OFS_GPIO_DATA_PORT_4: gp_data_q[3] <= io_wdata;
                default: sysmgmt_status_1_q <= sysmgmt_status_1_q;
            endcase
        end
    end

    wire parallel_int_status;
    assign parallel_int_status = parallel_port_power ? ack2_q : 1'b1;

    // ==========================================================
    // Read mux
    reg [7:0] rd_d;
    always @* begin
        rd_d = 8'h00;
        case (ofs)
            `OFS_WAKE_GLOBAL_STATUS: rd_d[`BIT_GLOBAL_STATUS] = global_sts_q;
            `OFS_WAKE_GLOBAL_ENABLE: rd_d[`BIT_GLOBAL_ENABLE] = global_en_q;
            `OFS_WAKE_SOURCE_STATUS_1: rd_d = src_sts_q[7:0];
            `OFS_WAKE_SOURCE_STATUS_2: rd_d = src_sts_q[15:8];
            `OFS_WAKE_SOURCE_STATUS_3: rd_d = src_sts_q[23:16];
            `OFS_WAKE_SOURCE_ENABLE_1: rd_d = src_en_q[7:0];
            `OFS_WAKE_SOURCE_ENABLE_2: rd_d = src_en_q[15:8];
            `OFS_WAKE_SOURCE_ENABLE_3: rd_d = src_en_q[23:16];
            `OFS_SYSMGMT_STATUS_1: rd_d = sysmgmt_status_1_q;
            `OFS_SYSMGMT_STATUS_2: rd_d = {sysmgmt_status_2_q[7:1], parallel_int_status};
            `OFS_SYSMGMT_ENABLE_1: rd_d = sysmgmt_enable_1_q;
            `OFS_SYSMGMT_ENABLE_2: rd_d = sysmgmt_enable_2_q;
            `OFS_GPIO_DATA_PORT_1: rd_d = gp_data_q[0];
            `OFS_GPIO_DATA_PORT_2: rd_d = gp_data_q[1];
            `OFS_GPIO_DATA_PORT_3: rd_d = gp_data_q[2];
            `OFS_GPIO_DATA_PORT_4: rd_d = gp_data_q[3];
            default: rd_d = 8'h00;
        endcase
    end

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            io_rdata <= 8'h00;
            io_rdata_valid <= 1'b0;
        end else begin
            io_rdata_valid <= hit & io_rd;
            // Undecoded reads return zero so a stale value never leaks
            io_rdata <= (hit & io_rd) ? rd_d : 8'h00;
        end
    end

    // ==========================================================
    // Wake output driver
    wire wake_active;
    wire act_high;
    wire push_pull;
    assign wake_active = global_en_q & global_sts_q;
    assign act_high = gpio_polarity_config_2[`BIT_WAKE_POLARITY];
    assign push_pull = gpio_driver_type_config[`BIT_WAKE_PUSH_PULL];

    wire level;
    assign level = wake_active ~^ act_high;

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            wake_event_out <= 1'b0;
            wake_event_oe <= 1'b0;
        end else if (push_pull) begin
            wake_event_out <= level;
            wake_event_oe <= 1'b1;
        end else begin
            // Open drain only ever pulls low; the high level comes from the pull-up
            wake_event_out <= 1'b0;
            wake_event_oe <= ~level;
        end
    end

endmodule
`default_nettype wire

// file: verilog/wake_event_defs.vh
// Offsets, field positions, reset values and masks of the wake event runtime block
`ifndef WAKE_EVENT_DEFS_VH
`define WAKE_EVENT_DEFS_VH

// ==========================================================
// Runtime register offsets within the 16-byte block
`define OFS_WAKE_GLOBAL_STATUS 4'h0
`define OFS_WAKE_GLOBAL_ENABLE 4'h1
`define OFS_WAKE_SOURCE_STATUS_1 4'h2
`define OFS_WAKE_SOURCE_STATUS_2 4'h3
`define OFS_WAKE_SOURCE_STATUS_3 4'h4
`define OFS_WAKE_SOURCE_ENABLE_1 4'h5
`define OFS_WAKE_SOURCE_ENABLE_2 4'h6
`define OFS_WAKE_SOURCE_ENABLE_3 4'h7
`define OFS_SYSMGMT_STATUS_1 4'h8
`define OFS_SYSMGMT_STATUS_2 4'h9
`define OFS_SYSMGMT_ENABLE_1 4'ha
`define OFS_SYSMGMT_ENABLE_2 4'hb
`define OFS_GPIO_DATA_PORT_1 4'hc
`define OFS_GPIO_DATA_PORT_2 4'hd
`define OFS_GPIO_DATA_PORT_3 4'he
`define OFS_GPIO_DATA_PORT_4 4'hf

// ==========================================================
// Reset values
`define RST_REG8 8'h00
`define RST_SYSMGMT_STATUS_2 8'h01
`define RST_SRC24 24'h00_0000

// ==========================================================
// Field positions
`define BIT_GLOBAL_STATUS 0
`define BIT_GLOBAL_ENABLE 0
`define BIT_PARALLEL_INT 0
`define BIT_WAKE_POLARITY 5
`define BIT_WAKE_PUSH_PULL 7

// ==========================================================
// Source vector layout: status 1 bits 7:0, status 2 bits 15:8, status 3 bits 23:16
`define SRC_COUNT 24
`define SRC_RING_A 8
`define SRC_RING_B 9
`define SRC_IMPLEMENTED_MASK 24'hFF_7FFF

// ==========================================================
// Address decode
`define ADDR_UPPER_ZERO 4'h0
`define BASE_MINIMUM 12'h100

`endif

// file: test/wake_event_runtime_block_chk.sv
// Port-level assertions for the wake event runtime block
`timescale 1ns/1ps
`default_nettype none
module wake_event_runtime_block_chk (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Register port
    input wire logic [15:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic io_rdata_valid,
    // Configuration and wake pin
    input wire logic [15:0] runtime_base_config,
    input wire logic [7:0] gpio_polarity_config_2,
    input wire logic [7:0] gpio_driver_type_config,
    input wire logic wake_event_out,
    input wire logic wake_event_oe
);
    // ==========================================================
    // Shadow of the decode and of the global enable
    logic hit;
    logic rd_hit;
    logic en_q;
    logic pol_q;
    logic pp_q;
    assign hit = io_addr[15:12] == 4'h0 && runtime_base_config[15:12] == 4'h0 &&
        runtime_base_config[11:0] >= 12'h100 && io_addr[11:4] == runtime_base_config[11:4];
    assign rd_hit = io_rd && hit;
    // Configs are flopped so they line up with the registered pin
    always @(posedge clk_sys) begin
        en_q <= sys_rst ? 1'b0 : (io_wr && hit && io_addr[3:0] == 4'h1) ? io_wdata[0] : en_q;
        pol_q <= gpio_polarity_config_2[5];
        pp_q <= gpio_driver_type_config[7];
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // ==========================================================
    // Assertions
    a_read_answer: assert property (rd_hit |=> io_rdata_valid)
        else $error("decoded read not answered");
    a_no_stray_valid: assert property (io_rdata_valid |-> $past(rd_hit))
        else $error("read valid without decoded read");
    a_low_base_off: assert property (io_rd && runtime_base_config[11:0] < 12'h100 |=> !io_rdata_valid)
        else $error("decode with base below minimum");
    a_reserved_read_zero: assert property (rd_hit && io_addr[3:1] == 3'h0 |=> io_rdata[7:1] == 7'h00)
        else $error("reserved bits read nonzero");
    a_gate_blocks_pin: assert property (!en_q && !$past(en_q) |-> !(wake_event_oe && wake_event_out == pol_q))
        else $error("wake pin active with global enable clear");
    a_reset_pin_idle: assert property (disable iff (1'b0) $fell(sys_rst) |-> !wake_event_oe && !io_rdata_valid)
        else $error("pin or read port busy at reset release");
    a_push_pull_drives: assert property (pp_q && !$past(sys_rst) |-> wake_event_oe)
        else $error("push-pull pin not driven");
    a_open_drain_low: assert property (!pp_q |-> !(wake_event_oe && wake_event_out))
        else $error("open-drain pin driven high");
    cover property (rd_hit);
    cover property (wake_event_oe && !pp_q);
    cover property (pp_q && wake_event_out);
endmodule
`default_nettype wire

// file: test/wake_host_model.sv
// Host chipset end of the wake line, with the board pull-up
`timescale 1ns/1ps
`default_nettype none
module wake_host_model (
    // Pin from the block
    input wire logic wake_event_out,
    input wire logic wake_event_oe,
    input wire logic active_high,
    // Line level and decoded wake
    output logic wake_line,
    output logic wake_seen
);
    // Released line floats to the pull-up, never the last driven value
    assign wake_line = wake_event_oe ? wake_event_out : 1'b1;
    assign wake_seen = wake_line == active_high;
endmodule
`default_nettype wire

// file: test/wake_event_runtime_block_tb.sv
// Self-checking bench for the wake event runtime block
`timescale 1ns/1ps
`default_nettype none
module wake_event_runtime_block_tb;
    logic clk_sys = 0, sys_rst = 1, io_wr = 0, io_rd = 0, ppwr = 0, ri_a = 1, ri_b = 1, ack = 1;
    // base inside the legal range, on a 16-byte boundary
    logic [15:0] io_addr = 16'h0000, base = 16'h0120;
    logic [7:0] io_wdata = 8'h00, pol2 = 8'h00, drv = 8'h00, io_rdata;
    // GPIO 1 inverted and held high so reset release gives no edge
    logic [20:0] gpol = 21'h00_0002, gin = 21'h00_0002;
    logic io_rdata_valid, wake_event_out, wake_event_oe, wake_line, wake_seen;
    int failures = 0, checks_done = 0;
    wake_event_runtime_block dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .io_addr(io_addr),
        .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .io_rdata_valid(io_rdata_valid), .runtime_base_config(base),
        .gpio_polarity_config_2(pol2), .gpio_driver_type_config(drv), .gpio_wake_polarity(gpol),
        .parallel_port_power(ppwr), .ring_indicate_in_a_n(ri_a), .ring_indicate_in_b_n(ri_b),
        .gpio_wake_in(gin), .printer_ack_in_n(ack), .wake_event_out(wake_event_out),
        .wake_event_oe(wake_event_oe));
    wake_host_model host (.wake_event_out(wake_event_out), .wake_event_oe(wake_event_oe),
        .active_high(pol2[5]), .wake_line(wake_line), .wake_seen(wake_seen));
    initial forever #2.5 clk_sys = ~clk_sys;
    // ==========================================================
    // Bus and compare tasks
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] ofs, input logic [7:0] d);
        @(posedge clk_sys);
        io_addr <= base + ofs;
        io_wdata <= d;
        io_wr <= 1'b1;
        @(posedge clk_sys);
        io_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
        @(posedge clk_sys);
        io_addr <= a;
        io_rd <= 1'b1;
        @(posedge clk_sys);
        io_rd <= 1'b0;
        #1;
        d = io_rdata;
        v = io_rdata_valid;
    endtask
    task automatic rchk(input logic [3:0] ofs, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        rd(base + ofs, d, v);
        chk("valid", 8'h01, {7'h00, v});
        chk("rdata", exp, d);
    endtask
    task automatic pin(input logic exp);
        #1;
        chk("wake_seen", {7'h00, exp}, {7'h00, wake_seen});
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset;
        for (int i = 0; i < 16; i++) begin
            rchk(i[3:0], i == 9 ? 8'h01 : 8'h00);
        end
    endtask
    task automatic t_gpio;
        @(posedge clk_sys);
        gin <= 21'h00_0001;
        repeat (6) @(posedge clk_sys);
        rchk(4'h2, 8'h03);
        rchk(4'h0, 8'h00);
        wr(4'h5, 8'h01);
        wr(4'h1, 8'h01);
        repeat (3) @(posedge clk_sys);
        rchk(4'h0, 8'h01);
        pin(1'b1);
        chk("line", 8'h00, {7'h00, wake_line});
        wr(4'h0, 8'h01);
        rchk(4'h0, 8'h01);
        wr(4'h2, 8'h00);
        rchk(4'h2, 8'h03);
        wr(4'h2, 8'h03);
        wr(4'h0, 8'h01);
        rchk(4'h0, 8'h00);
        pin(1'b0);
    endtask
    task automatic t_ring;
        @(posedge clk_sys);
        pol2 <= 8'h20;
        drv <= 8'h80;
        wr(4'h6, 8'h02);
        #1;
        chk("oe", 8'h01, {7'h00, wake_event_oe});
        pin(1'b0);
        @(posedge clk_sys);
        ri_a <= 1'b0;
        ri_b <= 1'b0;
        repeat (6) @(posedge clk_sys);
        rchk(4'h3, 8'h03);
        pin(1'b1);
        wr(4'h1, 8'h00);
        repeat (2) @(posedge clk_sys);
        pin(1'b0);
        rchk(4'h0, 8'h01);
    endtask
    task automatic t_decode;
        logic [7:0] d;
        logic v;
        rd(base | 16'h1000, d, v);
        chk("upper", 8'h00, {7'h00, v});
        rd(base + 16'h0010, d, v);
        chk("miss", 8'h00, {7'h00, v});
        @(posedge clk_sys);
        base <= 16'h00F0;
        rd(16'h00F0, d, v);
        chk("low", 8'h00, {7'h00, v});
        @(posedge clk_sys);
        base <= 16'h0120;
        ppwr <= 1'b1;
        ack <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rchk(4'h9, 8'h00);
    endtask
    task automatic wrap_up;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #50000;
        failures++;
        wrap_up;
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_reset;
        t_gpio;
        t_ring;
        t_decode;
        wrap_up;
    end
endmodule
bind wake_event_runtime_block wake_event_runtime_block_chk chk_i (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid),
    .runtime_base_config(runtime_base_config), .gpio_polarity_config_2(gpio_polarity_config_2),
    .gpio_driver_type_config(gpio_driver_type_config), .wake_event_out(wake_event_out),
    .wake_event_oe(wake_event_oe));
`default_nettype wire
